// ==== design/adc_device.sv ====
// converter end: samples select and conversion clock, shifts out the result
// Function
// - data changes on each conversion clock falling edge
// - host samples data on rising edge
// - host may sample falling edge if hold allows
// - select falling starts conversion and transfer
// - sample phase lasts 1.5 to 2 periods
// - second falling edge drives low null bit
// - twelve result bits follow, msb first
// - then result repeats lsb first
// - after msb repeated, output goes high impedance
// - later clocks change nothing while select low
// - new conversion needs select high then low
// - result is 12-bit straight binary code
// - power down after conversion or select high
// - analog off after conversion, digital off only on select
// - host should clock fast, idle select high
// - host clock between 10 kHz and 3.2 MHz
// - bits belong to current conversion, no latency
// - select high aborts and fully powers down
`timescale 1ns/1ps
module adc_device (
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	adc_link_if.device       link,
	input  wire logic [11:0] i_analog_code,
	output logic             o_analog_pd,
	output logic             o_digital_pd,
	output logic             o_sampling,
	output logic [11:0]      o_result
);
	// ***********************************************
	// pin synchronisers
	// ***********************************************
	logic [2:0] cs_sync_q;
	logic [2:0] clk_sync_q;
	logic       cs_n_q;
	logic       sclk_q;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cs_sync_q  <= 3'h7;
			clk_sync_q <= 3'h0;
		end else begin
			cs_sync_q  <= {cs_sync_q[1:0], link.cs_n};
			clk_sync_q <= {clk_sync_q[1:0], link.conversion_clock};
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			if (cs_sync_q[1] == cs_sync_q[2])
				cs_n_q <= cs_sync_q[2];
			if (clk_sync_q[1] == clk_sync_q[2])
				sclk_q <= clk_sync_q[2];
		end
	end

	logic cs_n_d1_q;
	logic sclk_d1_q;
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cs_n_d1_q <= 1'b1;
			sclk_d1_q <= 1'b0;
		end else begin
			cs_n_d1_q <= cs_n_q;
			sclk_d1_q <= sclk_q;
		end
	end

	logic cs_fall;
	logic sclk_fall;
	logic sclk_rise;
	assign cs_fall   = cs_n_d1_q & ~cs_n_q;
	assign sclk_fall = sclk_d1_q & ~sclk_q;
	assign sclk_rise = ~sclk_d1_q & sclk_q;

	// ***********************************************
	// bit sequencer
	// ***********************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_MSB_FIRST,
		ST_LSB_FIRST,
		ST_DONE
	} seq_state_t;

	seq_state_t  state_q;
	logic [4:0]  edge_cnt_q;
	logic [11:0] result_q;
	logic [3:0]  bit_idx_q;
	logic        dout_q;
	logic        oe_q;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q    <= ST_IDLE;
			edge_cnt_q <= 5'h00;
			bit_idx_q  <= 4'h0;
			dout_q     <= 1'b0;
			oe_q       <= 1'b0;
		end else if (cs_n_q) begin
			// abort: sequencer reset, output released, no bits left to send
			state_q    <= ST_IDLE;
			edge_cnt_q <= 5'h00;
			bit_idx_q  <= 4'h0;
			oe_q       <= 1'b0;
			dout_q     <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// only a fresh select fall starts work; a held-low select does not
					if (cs_fall) begin
						state_q    <= ST_SAMPLE;
						edge_cnt_q <= 5'h00;
					end
				end
				ST_SAMPLE: begin
					// sampling spans select fall up to the second falling edge
					if (sclk_fall) begin
						edge_cnt_q <= edge_cnt_q + 5'h01;
						if (edge_cnt_q + 5'h01 == adc_link_pkg::NULL_EDGE) begin
							oe_q      <= 1'b1;
							dout_q    <= 1'b0;
							bit_idx_q <= 4'hb;
							state_q   <= ST_MSB_FIRST;
						end
					end
				end
				ST_MSB_FIRST: begin
					if (sclk_fall) begin
						edge_cnt_q <= edge_cnt_q + 5'h01;
						dout_q     <= result_q[bit_idx_q];
						if (bit_idx_q == 4'h0) begin
							bit_idx_q <= 4'h1;
							state_q   <= ST_LSB_FIRST;
						end else begin
							bit_idx_q <= bit_idx_q - 4'h1;
						end
					end
				end
				ST_LSB_FIRST: begin
					if (sclk_fall) begin
						edge_cnt_q <= edge_cnt_q + 5'h01;
						// lsb is not sent twice: repeat starts at bit one
						if (edge_cnt_q + 5'h01 == adc_link_pkg::TRISTATE_EDGE) begin
							oe_q    <= 1'b0;
							state_q <= ST_DONE;
						end else begin
							dout_q    <= result_q[bit_idx_q];
							bit_idx_q <= bit_idx_q + 4'h1;
						end
					end
				end
				ST_DONE: begin
					state_q <= ST_DONE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ***********************************************
	// sample capture and power state
	// ***********************************************
	// code captured at the end of sampling, so it is this conversion's own
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			result_q <= adc_link_pkg::RESULT_RST;
		end else if (!cs_n_q && state_q == ST_SAMPLE && sclk_fall
				&& edge_cnt_q + 5'h01 == adc_link_pkg::NULL_EDGE) begin
			result_q <= i_analog_code;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_analog_pd  <= 1'b1;
			o_digital_pd <= 1'b1;
			o_sampling   <= 1'b0;
			o_result     <= adc_link_pkg::RESULT_RST;
		end else begin
			o_analog_pd  <= cs_n_q || state_q == ST_DONE || state_q == ST_IDLE;
			o_digital_pd <= cs_n_q;
			o_sampling   <= !cs_n_q && state_q == ST_SAMPLE;
			o_result     <= result_q;
		end
	end

	// rising edges are unused here: the host captures on them
	logic unused_rise;
	assign unused_rise = sclk_rise;

	assign link.dout_o  = dout_q;
	assign link.dout_oe = oe_q;

endmodule : adc_device

// ==== inc/adc_link_pkg.sv ====
// package of constants shared by both ends of the converter serial link
package adc_link_pkg;
	localparam int RESULT_BITS = 12;
	localparam logic [11:0] RESULT_RST = 12'h000;
	// conversion clock divider: 25 MHz / 8 = 3.125 MHz, under the 3.2 MHz ceiling
	localparam int CLK_HALF_CYC = 4;
	localparam int CLK_HALF_W = 3;
	// least select-high time between conversions, in conversion clock periods
	localparam int CS_IDLE_PER = 2;
	// falling edges after select falls before the null bit is driven
	localparam logic [4:0] NULL_EDGE = 5'h02;
	// falling edge at which the output goes high impedance: the one after null + 12 + 11 more
	localparam logic [4:0] TRISTATE_EDGE = 5'h1a;
	// frame length counted by the host, in falling edges
	localparam logic [4:0] FRAME_EDGES = 5'h1a;
endpackage : adc_link_pkg

// ==== inc/adc_link_if.sv ====
// interface joining the converter end and the host end of the serial link
`timescale 1ns/1ps
interface adc_link_if;
	logic cs_n;
	logic conversion_clock;
	logic dout_o;
	logic dout_oe;
	modport device (
		input  cs_n,
		input  conversion_clock,
		output dout_o,
		output dout_oe
	);
	modport host (
		output cs_n,
		output conversion_clock,
		input  dout_o,
		input  dout_oe
	);
endinterface : adc_link_if

// ==== design/adc_host.sv ====
// host end: drives select and conversion clock, captures the msb-first word
`timescale 1ns/1ps
module adc_host (
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	adc_link_if.host         link,
	input  wire logic        i_start,
	output logic             o_busy,
	output logic             o_done,
	output logic [11:0]      o_result
);
	// ***********************************************
	// data pin synchroniser
	// ***********************************************
	logic [2:0] din_sync_q;
	logic       din_q;
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			din_sync_q <= 3'h0;
			din_q      <= 1'b0;
		end else begin
			din_sync_q <= {din_sync_q[1:0], link.dout_o};
			if (din_sync_q[1] == din_sync_q[2])
				din_q <= din_sync_q[2];
		end
	end

	// ***********************************************
	// clock divider and frame sequencer
	// ***********************************************
	typedef enum logic [1:0] {
		H_IDLE,
		H_FRAME,
		H_TAIL,
		H_GAP
	} host_state_t;

	host_state_t state_q;
	logic [2:0]  div_q;
	logic        sclk_q;
	logic        cs_n_q;
	logic [4:0]  fall_cnt_q;
	logic [11:0] shift_q;
	logic [1:0]  gap_q;
	logic        half_tick;
	// one half period of the conversion clock
	assign half_tick = (div_q == 3'(adc_link_pkg::CLK_HALF_CYC - 1));

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_q <= 3'h0;
		end else if (state_q == H_IDLE || half_tick) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q    <= H_IDLE;
			sclk_q     <= 1'b0;
			cs_n_q     <= 1'b1;
			fall_cnt_q <= 5'h00;
			shift_q    <= 12'h000;
			gap_q      <= 2'h0;
			o_done     <= 1'b0;
			o_result   <= 12'h000;
		end else begin
			o_done <= 1'b0;
			case (state_q)
				H_IDLE: begin
					sclk_q <= 1'b0;
					if (i_start) begin
						cs_n_q     <= 1'b0;
						fall_cnt_q <= 5'h00;
						state_q    <= H_FRAME;
					end
				end
				H_FRAME: begin
					if (half_tick) begin
						sclk_q <= ~sclk_q;
						if (sclk_q) begin
							fall_cnt_q <= fall_cnt_q + 5'h01;
							if (fall_cnt_q + 5'h01 == adc_link_pkg::FRAME_EDGES) begin
								// select held low one more period: the converter must
								// see the last fall itself and release the line
								gap_q   <= 2'h0;
								state_q <= H_TAIL;
							end
						end else if (fall_cnt_q >= 5'h04 && fall_cnt_q <= 5'h0f) begin
							// both synchronisers add more than half a period, so the
							// bit launched at fall n is taken at the rise after fall n+1
							shift_q <= {shift_q[10:0], din_q};
							if (fall_cnt_q == 5'h0f) begin
								o_result <= {shift_q[10:0], din_q};
								o_done   <= 1'b1;
							end
						end
					end
				end
				H_TAIL: begin
					if (half_tick) begin
						if (gap_q == 2'h1) begin
							cs_n_q  <= 1'b1;
							gap_q   <= 2'h0;
							state_q <= H_GAP;
						end else begin
							gap_q <= gap_q + 2'h1;
						end
					end
				end
				H_GAP: begin
					// select stays high for the idle gap, counted in half periods
					if (half_tick) begin
						gap_q <= gap_q + 2'h1;
						if (gap_q == 2'(2 * adc_link_pkg::CS_IDLE_PER - 1))
							state_q <= H_IDLE;
					end
				end
				default: begin
					state_q <= H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n)
			o_busy <= 1'b0;
		else
			o_busy <= (state_q != H_IDLE) || i_start;
	end

	assign link.cs_n             = cs_n_q;
	assign link.conversion_clock = sclk_q;

endmodule : adc_host

// ==== dv/adc_link_chk.sv ====
// checker of the serial link wire between host end and converter end
`timescale 1ns/1ps
module adc_link_chk (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic cs_n,
	input wire logic conversion_clock,
	input wire logic dout_o,
	input wire logic dout_oe
);
	logic       clk_q;
	logic [4:0] falls_q;
	logic [3:0] since_q;
	logic [4:0] high_q;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	// counters lag the pin by one cycle, well inside the device's own sync lag
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clk_q <= 1'b0;
			falls_q <= 5'h00;
			since_q <= 4'hf;
			high_q <= 5'h1f;
		end else begin
			clk_q <= conversion_clock;
			if (cs_n) falls_q <= 5'h00;
			else if (clk_q && !conversion_clock && falls_q != 5'h1f) falls_q <= falls_q + 5'h01;
			if (clk_q && !conversion_clock) since_q <= 4'h0;
			else if (since_q != 4'hf) since_q <= since_q + 4'h1;
			if (!cs_n) high_q <= 5'h00;
			else if (high_q != 5'h1f) high_q <= high_q + 5'h01;
		end
	end
	// ****************************************
	// wire properties
	// ****************************************
	sequence s_high_half;
		conversion_clock[*4] ##1 !conversion_clock;
	endsequence
	sequence s_null_period;
		(dout_oe && !dout_o)[*8];
	endsequence
	a_clk_half_period: assert property ($rose(conversion_clock) |-> s_high_half)
		else $error("conversion clock high phase wrong");
	a_clk_low_select: assert property ($fell(cs_n) |-> !conversion_clock)
		else $error("clock high at select fall");
	a_cs_idle_gap: assert property ($fell(cs_n) |-> high_q >= 5'h0f)
		else $error("select high gap too short");
	a_null_first: assert property ($rose(dout_oe) |-> falls_q == 5'h02 ##0 s_null_period)
		else $error("null bit wrong");
	a_sample_quiet: assert property (falls_q < 5'h02 |-> !dout_oe)
		else $error("output driven in sample phase");
	a_tristate_edge: assert property ($fell(dout_oe) && !cs_n |-> falls_q == 5'h1a)
		else $error("tristate at wrong edge");
	a_bit_per_fall: assert property ($changed(dout_o) && dout_oe && $past(dout_oe)
		|-> since_q < 4'h7)
		else $error("data changed away from falling edge");
	a_idle_hiz: assert property (cs_n[*6] |-> !dout_oe)
		else $error("output driven while select high");
	a_frame_edges: assert property ($rose(cs_n) |-> falls_q == 5'h1a)
		else $error("frame edge count wrong");
endmodule : adc_link_chk

// ==== dv/sar_adc_serial_readout_tb.sv ====
// bench for both ends of the converter serial link
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
	logic        i_clk_sys = 1'b0;
	logic        i_arst_n = 1'b0;
	logic        start = 1'b0;
	logic [11:0] code = 12'h000;
	logic [11:0] code_b = 12'h000;
	logic        busy;
	logic        done;
	logic [11:0] res_h;
	logic [11:0] res_d;
	logic [11:0] res_b;
	logic [5:0]  pd;
	logic        pc = 1'b0;
	logic        hit_b = 1'b0;
	logic [15:0] lfsr = 16'h643b;
	logic [11:0] tbl [4] = '{12'h000, 12'h7ff, 12'h800, 12'hfff};
	logic        q[$];
	int          mismatches = 0;
	int          checks_done = 0;
	int          i;
	adc_link_if link_a ();
	adc_link_if link_b ();
	adc_host adc_host_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .link(link_a.host),
		.i_start(start), .o_busy(busy), .o_done(done), .o_result(res_h));
	adc_device adc_device_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .link(link_a.device),
		.i_analog_code(code), .o_analog_pd(pd[0]), .o_digital_pd(pd[1]),
		.o_sampling(pd[2]), .o_result(res_d));
	adc_device adc_device_f_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .link(link_b.device),
		.i_analog_code(code_b), .o_analog_pd(pd[3]), .o_digital_pd(pd[4]),
		.o_sampling(pd[5]), .o_result(res_b));
	adc_link_chk adc_link_chk_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .cs_n(link_a.cs_n),
		.conversion_clock(link_a.conversion_clock), .dout_o(link_a.dout_o),
		.dout_oe(link_a.dout_oe));
	always #20 i_clk_sys = ~i_clk_sys;
	// bits are taken one cycle after each fall, before the device moves on
	always @(posedge i_clk_sys) begin
		if (pc && !link_a.conversion_clock && !link_a.cs_n && link_a.dout_oe) q.push_back(link_a.dout_o);
		pc = link_a.conversion_clock;
		if (link_b.dout_oe === 1'b1) hit_b = 1'b1;
	end
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt
	task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({11'h000, got}, {11'h000, exp});
	endtask : cmp_bit
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : cyc
	task automatic falls_b(input int n);
		repeat (n) begin
			link_b.conversion_clock = 1'b1;
			cyc(4);
			link_b.conversion_clock = 1'b0;
			cyc(4);
		end
	endtask : falls_b
	task automatic frame_a(input logic [11:0] c);
		while (busy !== 1'b0) cyc(1);
		code = c;
		q.delete();
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cmp_bit(busy, 1'b1);
		for (i = 0; i < 400 && done !== 1'b1; i++) cyc(1);
		cmp_word(res_h, c);
		for (i = 0; i < 400 && link_a.cs_n !== 1'b1; i++) cyc(1);
		cyc(8);
		cmp_word(res_d, c);
		cmp_word(12'(q.size()), 12'h018);
		foreach (q[k]) cmp_bit(q[k], k == 0 ? 1'b0 : (k < 13 ? c[12 - k] : c[k - 12]));
		cmp_bit(pd[1], 1'b1);
		cmp_bit(pd[0], 1'b1);
	endtask : frame_a
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	initial begin
		link_b.cs_n = 1'b1;
		link_b.conversion_clock = 1'b0;
		cyc(20);
		i_arst_n = 1'b1;
		cyc(1);
		for (int n = 0; n < 10; n++) begin
			frame_a(n < 4 ? tbl[n] : lfsr[11:0]);
			lfsr = nxt(lfsr);
		end
		// far end driven by hand: clocks past the tristate edge, then an abort
		code_b = lfsr[11:0];
		link_b.cs_n = 1'b0;
		cyc(6);
		cmp_bit(pd[5], 1'b1);
		falls_b(26);
		cyc(6);
		cmp_bit(link_b.dout_oe, 1'b0);
		cmp_word(res_b, code_b);
		cmp_bit(pd[3], 1'b1);
		cmp_bit(pd[4], 1'b0);
		hit_b = 1'b0;
		falls_b(30);
		cmp_bit(hit_b, 1'b0);
		link_b.cs_n = 1'b1;
		cyc(16);
		link_b.cs_n = 1'b0;
		cyc(2);
		falls_b(8);
		cmp_bit(link_b.dout_oe, 1'b1);
		link_b.cs_n = 1'b1;
		cyc(8);
		cmp_bit(link_b.dout_oe, 1'b0);
		cmp_bit(pd[4], 1'b1);
		cmp_bit(pd[3], 1'b1);
		results();
	end
	initial begin
		#1000000;
		mismatches++;
		results();
	end
endmodule : sar_adc_serial_readout_tb
